// *** hw/ut_params.svh ***
`ifndef UT_PARAMS_SVH
`define UT_PARAMS_SVH
`define UT_A_CTRL1 3'h0
`define UT_A_CTRL2 3'h1
`define UT_A_STATUS 3'h2
`define UT_A_DATA 3'h3
`define UT_A_BAUD_DIVIDER_LOW 3'h4
`define UT_A_BAUD_DIVIDER_HIGH 3'h5
`define UT_A_FMC 3'h6
`define UT_BREAK_BITS 5'h0d
`define UT_CTRL1_RST 8'h00
`define UT_CTRL2_RST 8'h00
`endif

// *** hw/ut_pkg.sv ***
package ut_pkg;
  typedef enum logic [2:0] {
    UT_IDLE = 3'b000,
    UT_START = 3'b001,
    UT_DATA = 3'b010,
    UT_PAR = 3'b011,
    UT_STOP = 3'b100,
    UT_BRK = 3'b101
  } ut_state_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ut_bus_t;

  typedef struct packed {
    logic master_en;
    logic word9;
    logic par_en;
    logic [1:0] par_type;
    logic stop2;
    logic ninth_bit;
    logic tx_en;
    logic rx_en;
    logic brk;
    logic tx_empty_irq_enable;
    logic [15:0] baud_divider;
    logic [2:0] frac;
    logic [7:0] ctrl2_rest;
    logic [2:0] fmc_rest;
    ut_state_t st;
    logic [9:0] shreg;
    logic [3:0] bitn;
    logic [15:0] cnt;
    logic [3:0] acc;
    logic buf_full;
    logic [8:0] buf_data;
    logic tx_buffer_empty_flag;
    logic tx_idle_flag;
    logic stat_seen;
    logic [16:0] brk_hold;
    logic brk_arm;
    logic [4:0] brk_cnt;
    logic tx_pin;
    logic tx_oe_n;
    logic irq;
    logic [7:0] rdata;
  } ut_state_s_t;
endpackage : ut_pkg

// *** hw/ut_tx.sv ***
`timescale 1ns/1ps
`include "ut_params.svh"
module ut_tx
  import ut_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic o_tx_pin,
  output logic o_tx_oe_n,
  output logic o_tx_irq
);
  ut_state_s_t s_r, s_nxt;
  logic tick;
  logic [3:0] acc_sum;
  logic [8:0] word;

  // Parity over the data slots actually sent
  function automatic logic par_bit(input logic [1:0] t, input logic [8:0] d, input logic w9);
    logic x;
    // In the 8-bit word with parity the top slot is parity, so bit 7 is not sent
    x = w9 ? ^d[7:0] : ^d[6:0];
    unique case (t)
      2'b00: par_bit = x;
      2'b01: par_bit = ~x;
      2'b10: par_bit = 1'b1;
      2'b11: par_bit = 1'b0;
    endcase
  endfunction : par_bit

  // Fractional stretch: carry into bit 3 adds one clock to the bit
  assign acc_sum = {1'b0, s_r.acc[2:0]} + {1'b0, s_r.frac};
  assign tick = (s_r.cnt == 16'h0000);

  always_comb begin
    s_nxt = s_r;
    word = 9'h000;
    // Register reads
    s_nxt.rdata = 8'h00;
    if (i_rd) begin
      unique case (i_addr)
        `UT_A_CTRL1: s_nxt.rdata = {s_r.master_en, s_r.word9, s_r.par_en, s_r.par_type,
                                    s_r.stop2, 1'b0, s_r.ninth_bit};
        `UT_A_CTRL2: s_nxt.rdata = {s_r.tx_en, s_r.rx_en, s_r.tx_empty_irq_enable, s_r.brk, s_r.ctrl2_rest[3:0]};
        `UT_A_STATUS: s_nxt.rdata = {4'h0, 1'b1, s_r.tx_idle_flag, s_r.tx_buffer_empty_flag, 1'b0};
        `UT_A_BAUD_DIVIDER_LOW: s_nxt.rdata = s_r.baud_divider[7:0];
        `UT_A_BAUD_DIVIDER_HIGH: s_nxt.rdata = s_r.baud_divider[15:8];
        `UT_A_FMC: s_nxt.rdata = {2'b00, s_r.frac, s_r.fmc_rest};
        default: s_nxt.rdata = 8'h00;
      endcase
      if (i_addr == `UT_A_STATUS) s_nxt.stat_seen = 1'b1;
    end
    // Register writes; settings survive disable
    if (i_wr) begin
      unique case (i_addr)
        `UT_A_CTRL1: begin
          {s_nxt.master_en, s_nxt.word9, s_nxt.par_en, s_nxt.par_type, s_nxt.stop2} = i_wdata[7:2];
          s_nxt.ninth_bit = i_wdata[0];
        end
        `UT_A_CTRL2: begin
          {s_nxt.tx_en, s_nxt.rx_en, s_nxt.tx_empty_irq_enable, s_nxt.brk} = i_wdata[7:4];
          s_nxt.ctrl2_rest[3:0] = i_wdata[3:0];
        end
        `UT_A_BAUD_DIVIDER_LOW: s_nxt.baud_divider[7:0] = i_wdata;
        `UT_A_BAUD_DIVIDER_HIGH: s_nxt.baud_divider[15:8] = i_wdata;
        `UT_A_FMC: {s_nxt.frac, s_nxt.fmc_rest} = i_wdata[5:0];
        default: ;
      endcase
    end
    // Data write only accepted while buffer empty flag is high
    if (i_wr && i_addr == `UT_A_DATA && s_r.tx_buffer_empty_flag && s_r.master_en) begin
      word = {s_r.word9 ? s_r.ninth_bit : 1'b0, i_wdata};
      if (s_r.stat_seen) s_nxt.tx_idle_flag = 1'b0;
      s_nxt.stat_seen = 1'b0;
      s_nxt.buf_data = word;
      s_nxt.buf_full = 1'b1;
      s_nxt.tx_buffer_empty_flag = 1'b0;
    end
    // Baud counter reloads at each bit boundary
    if (s_r.st != UT_IDLE) begin
      if (tick) begin
        s_nxt.acc = {1'b0, acc_sum[2:0]};
        s_nxt.cnt = s_r.baud_divider - 16'h0001 + {15'h0000, acc_sum[3]};
      end else begin
        s_nxt.cnt = s_r.cnt - 16'h0001;
      end
    end
    // Break arming: hold longer than BAUD_DIVIDER+1 clocks while idle
    if (s_r.brk && s_r.tx_idle_flag) begin
      if (s_r.brk_hold > {1'b0, s_r.baud_divider}) s_nxt.brk_arm = 1'b1;
      else s_nxt.brk_hold = s_r.brk_hold + 17'h00001;
    end else begin
      s_nxt.brk_hold = 17'h00000;
    end
    // Transmit sequencer, LSB first
    unique case (s_r.st)
      UT_IDLE: begin
        s_nxt.tx_pin = 1'b1;
        if (s_r.tx_en && s_r.master_en) begin
          if (s_r.brk_arm && s_r.brk) begin
            s_nxt.st = UT_START;
            s_nxt.brk_cnt = 5'h00;
            s_nxt.tx_pin = 1'b0;
            s_nxt.cnt = s_r.baud_divider - 16'h0001;
            s_nxt.acc = {1'b0, s_r.frac};
            s_nxt.shreg = 10'h000;
            s_nxt.bitn = 4'hf; // Marks break frame
          end else if (s_r.buf_full) begin
            s_nxt.shreg = {1'b0, s_r.buf_data};
            s_nxt.buf_full = 1'b0;
            s_nxt.tx_buffer_empty_flag = 1'b1;
            s_nxt.st = UT_START;
            s_nxt.tx_pin = 1'b0;
            s_nxt.cnt = s_r.baud_divider - 16'h0001;
            s_nxt.acc = {1'b0, s_r.frac}; // Start bit takes the first addition
            s_nxt.bitn = 4'h0;
          end
        end
      end
      UT_START: if (tick) begin
        if (s_r.bitn == 4'hf) begin
          s_nxt.st = UT_BRK;
          s_nxt.tx_pin = 1'b0;
        end else begin
          s_nxt.st = UT_DATA;
          s_nxt.tx_pin = s_r.shreg[0];
          s_nxt.shreg = {1'b0, s_r.shreg[9:1]};
          s_nxt.bitn = 4'h1;
          s_nxt.shreg[9] = par_bit(s_r.par_type, s_r.shreg[8:0], s_r.word9);
        end
      end
      UT_DATA: if (tick) begin
        // Parity takes the last data slot of the word
        if (s_r.bitn == ((s_r.word9 ? 4'h9 : 4'h8) - {3'h0, s_r.par_en})) begin
          if (s_r.par_en) begin
            s_nxt.st = UT_PAR;
            s_nxt.tx_pin = s_r.shreg[9];
          end else begin
            s_nxt.st = UT_STOP;
            s_nxt.tx_pin = 1'b1;
            s_nxt.bitn = 4'h0;
          end
        end else begin
          s_nxt.tx_pin = s_r.shreg[0];
          s_nxt.shreg = {1'b0, s_r.shreg[9:1]};
          s_nxt.shreg[9] = s_r.shreg[9];
          s_nxt.bitn = s_r.bitn + 4'h1;
        end
      end
      UT_PAR: if (tick) begin
        s_nxt.st = UT_STOP;
        s_nxt.tx_pin = 1'b1;
        s_nxt.bitn = 4'h0;
      end
      UT_BRK: if (tick) begin
        if (s_r.brk_cnt == `UT_BREAK_BITS - 5'h01) begin
          s_nxt.brk_cnt = 5'h00;
          if (!s_r.brk) begin
            s_nxt.st = UT_STOP;
            s_nxt.tx_pin = 1'b1;
            s_nxt.bitn = 4'h0;
          end
        end else begin
          s_nxt.brk_cnt = s_r.brk_cnt + 5'h01;
        end
      end
      UT_STOP: if (tick) begin
        if (s_r.stop2 && s_r.bitn == 4'h0) begin
          s_nxt.bitn = 4'h1;
        end else begin
          s_nxt.st = UT_IDLE;
          s_nxt.tx_idle_flag = 1'b1;
          s_nxt.brk_arm = 1'b0;
        end
      end
      default: s_nxt.st = UT_IDLE;
    endcase
    // Transmit enable drop aborts the frame at once
    if (!s_r.tx_en && s_r.st != UT_IDLE) begin
      s_nxt.st = UT_IDLE;
      s_nxt.tx_pin = 1'b1;
      s_nxt.tx_idle_flag = 1'b1;
    end
    // Master disable: abort, flush buffer, reset flags
    if (!s_r.master_en) begin
      s_nxt.st = UT_IDLE;
      s_nxt.buf_full = 1'b0;
      s_nxt.tx_en = 1'b0;
      s_nxt.rx_en = 1'b0;
      s_nxt.brk = 1'b0;
      s_nxt.brk_arm = 1'b0;
      s_nxt.tx_buffer_empty_flag = 1'b1;
      s_nxt.tx_idle_flag = 1'b1;
      s_nxt.tx_pin = 1'b1;
    end
    // Pin released to shared use unless enabled
    s_nxt.tx_oe_n = ~(s_nxt.master_en & s_nxt.tx_en);
    // Break frames never raise the interrupt
    s_nxt.irq = s_nxt.tx_buffer_empty_flag & s_nxt.tx_empty_irq_enable & (s_nxt.st != UT_BRK) & ~s_nxt.brk_arm;
  end

  // Reset values give 8, N, 1 and idle high line
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      s_r <= '0;
      s_r.tx_buffer_empty_flag <= 1'b1;
      s_r.tx_idle_flag <= 1'b1;
      s_r.tx_pin <= 1'b1;
      s_r.tx_oe_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_rdata = s_r.rdata;
  assign o_tx_pin = s_r.tx_pin;
  assign o_tx_oe_n = s_r.tx_oe_n;
  assign o_tx_irq = s_r.irq;

  // Reset format is eight bits, no parity, one stop
  property p_por_format;
    @(posedge i_ref_clk) $rose(!i_rst) |-> (!s_r.word9 && !s_r.par_en && !s_r.stop2);
  endproperty
  a_por_format: assert property (p_por_format) else $error("bad reset format");
  property p_idle_high;
    @(posedge i_ref_clk) disable iff (i_rst) (s_r.st == UT_IDLE) |-> o_tx_pin;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("idle line low");
  property p_disable;
    @(posedge i_ref_clk) disable iff (i_rst)
      !s_r.master_en |=> (s_r.st == UT_IDLE && !s_r.buf_full && s_r.tx_buffer_empty_flag && s_r.tx_idle_flag);
  endproperty
  a_disable: assert property (p_disable) else $error("disable not clean");
  property p_block_wr;
    @(posedge i_ref_clk) disable iff (i_rst)
      (i_wr && i_addr == `UT_A_DATA && !s_r.tx_buffer_empty_flag && s_r.master_en) |=> $stable(s_r.buf_data);
  endproperty
  a_block_wr: assert property (p_block_wr) else $error("blocked write taken");
  property p_tx_enable_bit_abort;
    @(posedge i_ref_clk) disable iff (i_rst)
      (!s_r.tx_en && s_r.st != UT_IDLE) |=> (s_r.st == UT_IDLE);
  endproperty
  a_tx_enable_bit_abort: assert property (p_tx_enable_bit_abort) else $error("tx not stopped");
  // Launch: one idle cycle, then the start bit
  sequence s_launch;
    s_r.st == UT_IDLE ##1 s_r.st == UT_START;
  endsequence
  // Accepted data write while the buffer is free
  sequence s_accept;
    i_wr && i_addr == `UT_A_DATA && s_r.tx_buffer_empty_flag && s_r.master_en;
  endsequence
  property p_start_low;
    @(posedge i_ref_clk) disable iff (i_rst)
      s_launch |-> !o_tx_pin;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start bit not low");
  property p_brk_noirq;
    @(posedge i_ref_clk) disable iff (i_rst) (s_r.st == UT_BRK) |=> !o_tx_irq;
  endproperty
  a_brk_noirq: assert property (p_brk_noirq) else $error("irq during break");
  property p_frame_done;
    @(posedge i_ref_clk) disable iff (i_rst)
      (s_r.st == UT_STOP && s_nxt.st == UT_IDLE) |=> s_r.tx_idle_flag;
  endproperty
  a_frame_done: assert property (p_frame_done) else $error("idle flag not set");

  // Pin enable follows master and transmit enables
  property p_oe_follow;
    @(posedge i_ref_clk) disable iff (i_rst) o_tx_oe_n == !(s_r.master_en && s_r.tx_en);
  endproperty
  a_oe_follow: assert property (p_oe_follow) else $error("pin enable wrong");

  // Disable drops the enables and the break request
  property p_disable_ctrl;
    @(posedge i_ref_clk) disable iff (i_rst)
      !s_r.master_en |=> (!s_r.tx_en && !s_r.rx_en && !s_r.brk && !s_r.brk_arm);
  endproperty
  a_disable_ctrl: assert property (p_disable_ctrl) else $error("disable left enables");

  // Settings survive the disable; only bus writes change them
  property p_keep_cfg;
    @(posedge i_ref_clk) disable iff (i_rst)
      (!s_r.master_en && !i_wr) |=> ($stable(s_r.baud_divider) && $stable(s_r.frac) && $stable(s_r.stop2));
  endproperty
  a_keep_cfg: assert property (p_keep_cfg) else $error("settings lost");

  // An accepted byte lands in the single buffer slot
  property p_accept;
    @(posedge i_ref_clk) disable iff (i_rst)
      s_accept |=> (s_r.buf_full && !s_r.tx_buffer_empty_flag && s_r.buf_data[7:0] == $past(i_wdata));
  endproperty
  a_accept: assert property (p_accept) else $error("write not buffered");

  // Ninth slot comes from the control bit, never the bus
  property p_ninth;
    @(posedge i_ref_clk) disable iff (i_rst)
      s_accept |=> (s_r.buf_data[8] == ($past(s_r.word9) & $past(s_r.ninth_bit)));
  endproperty
  a_ninth: assert property (p_ninth) else $error("ninth bit wrong");

  // Idle transmitter moves a waiting byte at once
  property p_load;
    @(posedge i_ref_clk) disable iff (i_rst)
      (s_r.st == UT_IDLE && s_r.buf_full && s_r.tx_en && s_r.master_en && !(s_r.brk_arm && s_r.brk))
        |=> (s_r.st == UT_START && s_r.tx_buffer_empty_flag && !s_r.buf_full);
  endproperty
  a_load: assert property (p_load) else $error("idle load missed");

  // Waiting byte stays put until the frame is over
  property p_hold_buf;
    @(posedge i_ref_clk) disable iff (i_rst)
      (s_r.st != UT_IDLE && s_r.buf_full && s_r.tx_en && s_r.master_en) |=> s_r.buf_full;
  endproperty
  a_hold_buf: assert property (p_hold_buf) else $error("early reload");

  // Stop slots are always high
  property p_stop_high;
    @(posedge i_ref_clk) disable iff (i_rst) (s_r.st == UT_STOP) |-> o_tx_pin;
  endproperty
  a_stop_high: assert property (p_stop_high) else $error("stop bit low");

  // Break body is low and its counter stays in range
  property p_brk_low;
    @(posedge i_ref_clk) disable iff (i_rst)
      (s_r.st == UT_BRK) |-> (!o_tx_pin && s_r.brk_cnt < `UT_BREAK_BITS);
  endproperty
  a_brk_low: assert property (p_brk_low) else $error("break body wrong");

  // Released break finishes with stop bits
  property p_brk_end;
    @(posedge i_ref_clk) disable iff (i_rst)
      (s_r.st == UT_BRK && tick && s_r.brk_cnt == `UT_BREAK_BITS - 5'h01 && !s_r.brk &&
       s_r.tx_en && s_r.master_en) |=> (s_r.st == UT_STOP && o_tx_pin);
  endproperty
  a_brk_end: assert property (p_brk_end) else $error("break not ended");

  // Held break starts another break character
  property p_brk_again;
    @(posedge i_ref_clk) disable iff (i_rst)
      (s_r.st == UT_BRK && tick && s_r.brk_cnt == `UT_BREAK_BITS - 5'h01 && s_r.brk &&
       s_r.tx_en && s_r.master_en) |=> (s_r.st == UT_BRK && s_r.brk_cnt == 5'h00);
  endproperty
  a_brk_again: assert property (p_brk_again) else $error("break not repeated");

  // Long enough hold while idle arms the break
  property p_brk_arm;
    @(posedge i_ref_clk) disable iff (i_rst)
      (s_r.brk && s_r.tx_idle_flag && s_r.master_en && s_r.st == UT_IDLE &&
       s_r.brk_hold > {1'b0, s_r.baud_divider}) |=> s_r.brk_arm;
  endproperty
  a_brk_arm: assert property (p_brk_arm) else $error("break not armed");

  // Arming never comes before the hold time has passed
  property p_brk_late;
    @(posedge i_ref_clk) disable iff (i_rst)
      $rose(s_r.brk_arm) |-> ($past(s_r.brk_hold) > {1'b0, $past(s_r.baud_divider)});
  endproperty
  a_brk_late: assert property (p_brk_late) else $error("break armed early");

  // Each bit reloads BAUD_DIVIDER clocks, one more on a carry
  property p_bit_len;
    @(posedge i_ref_clk) disable iff (i_rst)
      (s_r.st != UT_IDLE && tick && !i_wr) |=>
        (s_r.cnt == s_r.baud_divider - 16'h0001 + {15'h0000, $past(acc_sum[3])});
  endproperty
  a_bit_len: assert property (p_bit_len) else $error("bit time wrong");

  // Status read then data write clears both flags
  property p_clear_flags;
    @(posedge i_ref_clk) disable iff (i_rst)
      (s_accept ##0 (s_r.stat_seen && s_r.st == UT_IDLE)) |=> (!s_r.tx_idle_flag && !s_r.tx_buffer_empty_flag);
  endproperty
  a_clear_flags: assert property (p_clear_flags) else $error("flags not cleared");

  // Outside breaks the request mirrors the enabled flag
  property p_irq;
    @(posedge i_ref_clk) disable iff (i_rst)
      (s_r.st != UT_BRK && !s_r.brk_arm) |-> (o_tx_irq == (s_r.tx_buffer_empty_flag && s_r.tx_empty_irq_enable));
  endproperty
  a_irq: assert property (p_irq) else $error("irq wrong");
endmodule : ut_tx

// *** tb/ut_rx_model.sv ***
`timescale 1ns/1ps
// Far-end receiver, samples the line mid-bit at a fixed divider
module ut_rx_model (
  input wire logic i_ref_clk,
  input wire logic i_line,
  input wire logic [15:0] i_brd,
  input wire logic [4:0] i_nbits,
  output logic [15:0] o_frame,
  output int o_count
);
  // Low level arms, mid start bit recheck rejects glitches
  initial begin
    o_frame = 16'h0000;
    o_count = 0;
    forever begin
      @(posedge i_ref_clk);
      if (i_line === 1'b0) begin
        repeat (i_brd / 2) @(posedge i_ref_clk);
        if (i_line === 1'b0) begin
          o_frame = 16'h0000;
          // Bits land LSB first, one bit time apart
          for (int i = 0; i < i_nbits; i++) begin
            repeat (i_brd) @(posedge i_ref_clk);
            o_frame[i] = i_line;
          end
          o_count++;
        end
      end
    end
  end
endmodule : ut_rx_model

// *** tb/uart_transmitter_framing_test.sv ***
`timescale 1ns/1ps
`include "ut_params.svh"
module uart_transmitter_framing_test
  import ut_pkg::*;
;
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] o_rdata;
  logic o_tx_pin;
  logic o_tx_oe_n;
  logic o_tx_irq;
  logic line;
  logic [15:0] frame;
  logic [4:0] nb = 5'h09;
  logic [7:0] rv;
  logic [7:0] d;
  logic [3:0] pv;
  int frames;
  int nf = 0;
  int miscompares = 0;
  int cmp_count = 0;

  always #10 i_ref_clk = ~i_ref_clk;
  // Released pin has a pull-up, so it reads as idle
  assign line = o_tx_oe_n ? 1'b1 : o_tx_pin;
  int low_cnt = 0;
  int low_len = 0;
  // Length of the last low run on the line, in clocks
  always @(posedge i_ref_clk) begin
    if (line === 1'b0) begin
      low_cnt <= low_cnt + 1;
    end else begin
      if (low_cnt != 0) low_len <= low_cnt;
      low_cnt <= 0;
    end
  end

  ut_tx u_dut (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rdata(o_rdata),
    .o_tx_pin(o_tx_pin),
    .o_tx_oe_n(o_tx_oe_n),
    .o_tx_irq(o_tx_irq)
  );
  // Divider fixed at 16, fraction left at zero
  ut_rx_model u_far (
    .i_ref_clk(i_ref_clk),
    .i_line(line),
    .i_brd(16'h0010),
    .i_nbits(nb),
    .o_frame(frame),
    .o_count(frames)
  );

  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Gap cycle after each strobe keeps one assignment per time step
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
    @(posedge i_ref_clk);
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1;
    v = o_rdata;
    @(posedge i_ref_clk);
  endtask : rd

  // Status access first, otherwise the idle flag stays set
  task automatic send(input logic [7:0] v);
    rd(`UT_A_STATUS, rv);
    chk("tx_buffer_empty_flag", {15'h0, rv[1]}, 16'h0001);
    wr(`UT_A_DATA, v);
  endtask : send

  task automatic wait_frame(input logic [15:0] exp);
    nf++;
    for (int i = 0; i < 1000 && frames < nf; i++) @(posedge i_ref_clk);
    chk("frame", frame, exp);
    repeat (32) @(posedge i_ref_clk);
  endtask : wait_frame

  initial begin
    repeat (20000) @(posedge i_ref_clk);
    miscompares++;
    stop_test();
  end

  initial begin
    repeat (3) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    @(posedge i_ref_clk);
    chk("pins", {13'h0, o_tx_pin, o_tx_oe_n, o_tx_irq}, 16'h0006);
    rd(`UT_A_CTRL1, rv);
    chk("ctrl1", {8'h0, rv}, 16'h0000);
    wr(`UT_A_CTRL1, 8'h80);
    wr(`UT_A_BAUD_DIVIDER_LOW, 8'h10);
    wr(`UT_A_BAUD_DIVIDER_HIGH, 8'h00);
    wr(`UT_A_CTRL2, 8'ha0);
    repeat (2) @(posedge i_ref_clk);
    chk("pins", {13'h0, o_tx_pin, o_tx_oe_n, o_tx_irq}, 16'h0005);
    send(8'ha5);
    wait_frame({7'h0, 1'b1, 8'ha5});
    // Parity takes the last word slot, seven data bits remain
    for (int t = 0; t < 4; t++) begin
      d = 8'h5a ^ 8'(t);
      pv = {1'b0, 1'b1, ~^d[6:0], ^d[6:0]};
      wr(`UT_A_CTRL1, 8'ha0 | 8'(t << 3));
      send(d);
      wait_frame({7'h0, 1'b1, pv[t], d[6:0]});
    end
    nb = 5'h0b;
    wr(`UT_A_CTRL1, 8'hc5);
    send(8'h3c);
    wait_frame({5'h0, 2'b11, 1'b1, 8'h3c});
    // Second byte waits in the buffer, third is refused
    nb = 5'h09;
    wr(`UT_A_CTRL1, 8'h80);
    send(8'h11);
    send(8'h22);
    wr(`UT_A_DATA, 8'h33);
    rd(`UT_A_STATUS, rv);
    chk("full", {14'h0, rv[1], o_tx_irq}, 16'h0000);
    wait_frame({7'h0, 1'b1, 8'h11});
    wait_frame({7'h0, 1'b1, 8'h22});
    repeat (300) @(posedge i_ref_clk);
    chk("frames", 16'(frames), 16'(nf));
    rd(`UT_A_STATUS, rv);
    chk("idle", {14'h0, rv[2:1]}, 16'h0003);
    // Abort mid-frame; divider is not rewritten on re-enable
    send(8'hff);
    repeat (48) @(posedge i_ref_clk);
    wr(`UT_A_CTRL1, 8'h28);
    chk("oe_n", {15'h0, o_tx_oe_n}, 16'h0001);
    rd(`UT_A_STATUS, rv);
    chk("status", {13'h0, rv[3:1]}, 16'h0007);
    rd(`UT_A_CTRL2, rv);
    chk("ctrl2", {8'h0, rv}, 16'h0020);
    repeat (400) @(posedge i_ref_clk);
    nf = frames;
    wr(`UT_A_CTRL1, 8'ha8);
    wr(`UT_A_CTRL2, 8'h80);
    send(8'h0f);
    wait_frame({7'h0, 1'b1, 1'b1, 7'h0f});
    // Fraction 4/8: every second bit gains a clock, D0 first
    wr(`UT_A_FMC, 8'h20);
    send(8'h00);
    wait_frame({7'h0, 1'b1, 1'b1, 7'h00});
    chk("lowfrac", 16'(low_len), 16'h0084);
    // Held break: start plus 13 zero bits, no irq meanwhile
    wr(`UT_A_FMC, 8'h00);
    wr(`UT_A_CTRL2, 8'hb0);
    repeat (60) @(posedge i_ref_clk);
    chk("brkirq", {15'h0, o_tx_irq}, 16'h0000);
    chk("brkline", {15'h0, line}, 16'h0000);
    wr(`UT_A_CTRL2, 8'ha0);
    repeat (300) @(posedge i_ref_clk);
    chk("brklow", 16'(low_len), 16'h00e0);
    chk("brkend", {14'h0, line, o_tx_irq}, 16'h0003);
    stop_test();
  end
endmodule : uart_transmitter_framing_test
